// *** rlr_pkg.sv ***
// Package for the return-with-literal and rotate-through-carry datapath
package rlr_pkg;
	// ****************************************
	// Widths and sizes
	// ****************************************
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 7;
	localparam int PC_W     = 15;
	localparam int STACK_N  = 16;
	localparam int SP_W     = 4;
	localparam int MSB      = DATA_W - 1;
	localparam int RET_CYC  = 2;
	localparam int ROT_CYC  = 1;
	localparam logic [7:0] W_RST = 8'h00;

	// ****************************************
	// Operation codes
	// ****************************************
	typedef enum logic [1:0] {
		OP_NONE,
		OP_RET_LIT,
		OP_ROT_LEFT,
		OP_ROT_RIGHT
	} rlr_op_e;

	// Instruction presented by the decoder
	typedef struct packed {
		rlr_op_e              op;
		logic [DATA_W-1:0]    literal;
		logic [ADDR_W-1:0]    faddr;
		logic                 dest;
	} rlr_instr_s;

	// File register write request
	typedef struct packed {
		logic                 we;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    data;
	} rlr_fwr_s;
endpackage

// *** rlr_core.sv ***
// Datapath for return-with-literal and the two rotate-through-carry ops
`timescale 1ns/1ps
module rlr_core #(
	parameter int STACK_N = rlr_pkg::STACK_N
) (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          sys_rst,
	// Instruction in, one per cycle while accepted
	input  wire rlr_pkg::rlr_instr_s           instr,
	input  wire logic                          instr_valid,
	output logic                               instr_ready,
	// File register read data for instr.faddr
	input  wire logic [rlr_pkg::DATA_W-1:0]    file_rdata,
	// Call stack push from the rest of the core
	input  wire logic                          push,
	input  wire logic [rlr_pkg::PC_W-1:0]      push_addr,
	// Results
	output logic [rlr_pkg::DATA_W-1:0]         work_reg,
	output logic                               carry,
	output rlr_pkg::rlr_fwr_s                  file_wr,
	output logic [rlr_pkg::PC_W-1:0]           pc_load,
	output logic                               pc_load_en,
	output logic                               flush,
	output logic [rlr_pkg::PC_W-1:0]           stack_top_entry,
	output logic [rlr_pkg::SP_W-1:0]           stack_depth
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [rlr_pkg::SP_W-1:0] sp_step(
		input logic [rlr_pkg::SP_W-1:0] sp,
		input logic up
	);
		sp_step = up ? sp + 4'h1 : sp - 4'h1;
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef enum logic {ST_RUN, ST_FLUSH} rlr_state_e;
	rlr_state_e                    state_r, state_nxt;
	logic [rlr_pkg::PC_W-1:0]      stack_r [STACK_N];
	logic [rlr_pkg::SP_W-1:0]      sp_r;
	logic [rlr_pkg::DATA_W-1:0]    work_r;
	logic                          carry_r;
	rlr_pkg::rlr_fwr_s             fwr_r;
	logic [rlr_pkg::PC_W-1:0]      pc_r;
	logic                          pc_en_r;
	logic                          flush_r;
	logic                          ready_r;

	// ****************************************
	// Decode
	// ****************************************
	wire logic go      = instr_valid && (state_r == ST_RUN);
	wire logic do_ret  = go && instr.op == rlr_pkg::OP_RET_LIT;
	wire logic do_rl   = go && instr.op == rlr_pkg::OP_ROT_LEFT;
	wire logic do_rr   = go && instr.op == rlr_pkg::OP_ROT_RIGHT;
	wire logic do_rot  = do_rl || do_rr;
	wire logic [rlr_pkg::SP_W-1:0] top_idx = sp_r - 4'h1;
	wire logic [rlr_pkg::PC_W-1:0] top_addr = stack_r[top_idx];
	// Rotated value and carry out
	wire logic [rlr_pkg::DATA_W-1:0] rot_val = do_rl ?
		{file_rdata[rlr_pkg::MSB-1:0], carry_r} :
		{carry_r, file_rdata[rlr_pkg::MSB:1]};
	wire logic rot_c = do_rl ? file_rdata[rlr_pkg::MSB] :
		file_rdata[0];
	wire logic push_ok = push && !do_ret;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN:   if (do_ret) state_nxt = ST_FLUSH;
			ST_FLUSH: state_nxt = ST_RUN;
			default:  state_nxt = ST_RUN;
		endcase
	end

	// ****************************************
	// Sequential
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= ST_RUN;
			sp_r    <= '0;
			work_r  <= rlr_pkg::W_RST;
			carry_r <= 1'b0;
			fwr_r   <= '0;
			pc_r    <= '0;
			pc_en_r <= 1'b0;
			flush_r <= 1'b0;
			ready_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			pc_en_r <= do_ret;
			flush_r <= do_ret;
			ready_r <= !do_ret;
			if (do_ret) begin
				work_r <= instr.literal;
				pc_r   <= top_addr;
				sp_r   <= sp_step(sp_r, 1'b0);
			end else if (push_ok) begin
				sp_r   <= sp_step(sp_r, 1'b1);
			end
			if (do_rot) begin
				carry_r <= rot_c;
				if (!instr.dest)
					work_r <= rot_val;
			end
			fwr_r.we   <= do_rot && instr.dest;
			fwr_r.addr <= instr.faddr;
			fwr_r.data <= rot_val;
		end
	end

	always_ff @(posedge clock) begin
		if (push_ok && !sys_rst)
			stack_r[sp_r] <= push_addr;
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic [rlr_pkg::PC_W-1:0] top_out_r;
	logic [rlr_pkg::SP_W-1:0] depth_r;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			top_out_r <= '0;
			depth_r   <= '0;
		end else begin
			top_out_r <= top_addr;
			depth_r   <= sp_r;
		end
	end

	assign instr_ready     = ready_r;
	assign work_reg        = work_r;
	assign carry           = carry_r;
	assign file_wr         = fwr_r;
	assign pc_load         = pc_r;
	assign pc_load_en      = pc_en_r;
	assign flush           = flush_r;
	assign stack_top_entry = top_out_r;
	assign stack_depth     = depth_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_ret;
		do_ret;
	endsequence
	sequence s_ret_done;
		pc_en_r && flush_r && !ready_r ##1 ready_r;
	endsequence

	a_ret_literal_w: assert property (s_ret |=> work_r == $past(instr.literal))
		else $error("literal not loaded into W");
	a_ret_pc_load: assert property (s_ret |=> pc_r == $past(top_addr))
		else $error("pc not loaded from stack top");
	a_ret_pop: assert property (s_ret |=> sp_r == $past(sp_r) - 4'h1)
		else $error("stack not popped");
	a_ret_two_cyc: assert property (s_ret |=> s_ret_done)
		else $error("return did not take two cycles");
	a_rol_value: assert property (do_rl && !instr.dest |=>
		work_r == {$past(file_rdata[6:0]), $past(carry_r)})
		else $error("rotate left value wrong");
	a_rol_dest: assert property (do_rl && instr.dest |=>
		fwr_r.we && fwr_r.data == {$past(file_rdata[6:0]), $past(carry_r)}
		&& work_r == $past(work_r))
		else $error("rotate left destination wrong");
	a_ror_value: assert property (do_rr && !instr.dest |=>
		work_r == {$past(carry_r), $past(file_rdata[7:1])})
		else $error("rotate right value wrong");
	a_ror_dest: assert property (do_rr |=> fwr_r.we == $past(instr.dest))
		else $error("rotate right destination wrong");
	a_rot_carry: assert property (do_rot |=>
		carry_r == ($past(do_rl) ? $past(file_rdata[7]) : $past(file_rdata[0]))
		&& ready_r)
		else $error("rotate carry wrong");

	// Rotate steps: taken at one edge, result shown at the next
	sequence s_rol_w;
		do_rl && !instr.dest;
	endsequence
	sequence s_ror_f;
		do_rr && instr.dest;
	endsequence
	sequence s_rot_end;
		!pc_en_r && !flush_r && ready_r;
	endsequence

	a_rol_keep_file: assert property (s_rol_w |=> !fwr_r.we)
		else $error("rotate left to W also wrote the file register");
	a_ror_file_data: assert property (s_ror_f |=>
		fwr_r.data == {$past(carry_r), $past(file_rdata[7:1])}
		&& fwr_r.addr == $past(instr.faddr)
		&& work_r == $past(work_r))
		else $error("rotate right file write wrong");
	a_rot_one_cyc: assert property (do_rot |=> s_rot_end)
		else $error("rotate did not finish in one cycle");
	a_rot_pc_hold: assert property (do_rot |=> pc_r == $past(pc_r))
		else $error("rotate changed the program counter load");
	a_flush_refuse: assert property (state_r == ST_FLUSH |=>
		!fwr_r.we && !pc_en_r && carry_r == $past(carry_r)
		&& work_r == $past(work_r))
		else $error("instruction taken during the flush cycle");
	a_stack_push: assert property (push_ok |=>
		sp_r == $past(sp_r) + 4'h1)
		else $error("push did not grow the stack");
endmodule // rlr_core

// *** rlr_tb_top.sv ***
// Self-checking bench for the return and rotate-through-carry datapath
`timescale 1ns/1ps
module rlr_tb_top;
	// ****************************************
	// Signals and model state
	// ****************************************
	logic                clock;
	logic                sys_rst;
	logic                instr_valid;
	logic                push;
	logic                instr_ready;
	logic                carry;
	logic                pc_load_en;
	logic                flush;
	logic                e_c;
	logic                e_rdy;
	logic                e_en;
	logic                e_we;
	logic                tk;
	rlr_pkg::rlr_instr_s instr;
	rlr_pkg::rlr_fwr_s   file_wr;
	logic [7:0]          file_rdata;
	logic [7:0]          work_reg;
	logic [7:0]          e_w;
	logic [7:0]          e_d;
	logic [7:0]          r;
	logic [6:0]          e_a;
	logic [14:0]         push_addr;
	logic [14:0]         pc_load;
	logic [14:0]         e_pc;
	logic [14:0]         stack_top_entry;
	logic [14:0]         e_top;
	logic [3:0]          stack_depth;
	logic [3:0]          e_dep;
	logic [14:0]         q[$];
	int                  err_count = 0;
	int                  n_checks = 0;
	int                  cyc = 0;

	rlr_core uut (.clock(clock), .sys_rst(sys_rst), .instr(instr),
		.instr_valid(instr_valid), .instr_ready(instr_ready),
		.file_rdata(file_rdata), .push(push), .push_addr(push_addr),
		.work_reg(work_reg), .carry(carry), .file_wr(file_wr),
		.pc_load(pc_load), .pc_load_en(pc_load_en), .flush(flush),
		.stack_top_entry(stack_top_entry), .stack_depth(stack_depth));

	// ****************************************
	// Reference model, updated at each taking edge
	// ****************************************
	always @(posedge clock) begin
		e_en = 1'b0;
		e_we = 1'b0;
		if (sys_rst) begin
			e_w = rlr_pkg::W_RST;
			e_c = 1'b0;
			e_rdy = 1'b1;
			q.delete();
			e_dep = 4'h0;
			e_top = 15'h0000;
		end else begin
			// Stack views show the state from before this edge
			e_dep = 4'(q.size());
			if (q.size() > 0) e_top = q[$];
			tk = instr_valid && e_rdy;
			if (tk && instr.op == rlr_pkg::OP_RET_LIT) begin
				e_w = instr.literal;
				e_pc = q.pop_back();
				e_en = 1'b1;
			end else begin
				if (push) q.push_back(push_addr);
				if (tk && instr.op != rlr_pkg::OP_NONE) begin
					r = (instr.op == rlr_pkg::OP_ROT_LEFT) ?
						{file_rdata[6:0], e_c} : {e_c, file_rdata[7:1]};
					e_c = (instr.op == rlr_pkg::OP_ROT_LEFT) ?
						file_rdata[7] : file_rdata[0];
					e_we = instr.dest;
					e_a = instr.faddr;
					e_d = r;
					if (!instr.dest) e_w = r;
				end
			end
			e_rdy = !e_en;
		end
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ****************************************
	// Comparison at every result
	// ****************************************
	task automatic chk(input string nm, input logic [14:0] s, x);
		n_checks++;
		if (s !== x) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask

	always @(negedge clock) begin
		if (!sys_rst) begin
			chk("work_reg", work_reg, e_w);
			chk("carry", carry, e_c);
			chk("pc_load_en", pc_load_en, e_en);
			chk("flush", flush, e_en);
			chk("instr_ready", instr_ready, e_rdy);
			chk("file_wr_we", file_wr.we, e_we);
			if (e_we) chk("file_wr", {file_wr.addr, file_wr.data}, {e_a, e_d});
			if (e_en) chk("pc_load", pc_load, e_pc);
			chk("stack_depth", stack_depth, e_dep);
			if (e_dep != 4'h0)
				chk("stack_top", stack_top_entry, e_top);
		end
	end

	// ****************************************
	// Stimulus
	// ****************************************
	task automatic drv(input rlr_pkg::rlr_op_e op, input logic [7:0] lit,
		input logic v, p);
		@(posedge clock);
		instr <= '{op, lit, 7'($urandom), 1'($urandom)};
		instr_valid <= v;
		file_rdata <= 8'($urandom);
		push <= p;
		push_addr <= 15'($urandom);
	endtask

	function automatic rlr_pkg::rlr_op_e rot();
		return rlr_pkg::rlr_op_e'(2'($urandom_range(2, 3)));
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial begin
		sys_rst = 1'b1;
		instr = '0;
		instr_valid = 1'b0;
		file_rdata = 8'h00;
		push = 1'b0;
		push_addr = 15'h0000;
		void'($urandom(32'hab1f));
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			// Two pushes, then two returns; a push during a return is dropped
			drv(rlr_pkg::OP_NONE, 8'h00, 1'b0, 1'b1);
			drv(rlr_pkg::OP_NONE, 8'h00, 1'b0, 1'b1);
			drv(rlr_pkg::OP_RET_LIT, (i == 0) ? 8'hff : 8'($urandom), 1'b1,
				1'($urandom));
			drv(rot(), 8'h00, 1'b1, 1'b0);
			drv(rlr_pkg::OP_RET_LIT, (i == 0) ? 8'h00 : 8'($urandom), 1'b1,
				1'b0);
			drv(rot(), 8'h00, 1'b1, 1'b0);
			repeat (3) drv(rot(), 8'h00, 1'($urandom), 1'b0);
		end
		// Reset with one entry stacked must leave the stack empty
		drv(rlr_pkg::OP_NONE, 8'h00, 1'b0, 1'b1);
		drv(rot(), 8'h00, 1'b1, 1'b0);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		drv(rlr_pkg::OP_NONE, 8'h00, 1'b0, 1'b1);
		drv(rlr_pkg::OP_RET_LIT, 8'($urandom), 1'b1, 1'b0);
		drv(rlr_pkg::OP_NONE, 8'h00, 1'b0, 1'b0);
		repeat (2) @(posedge clock);
		tally_and_finish();
	end
endmodule // rlr_tb_top
